// *** core/fww_pkg.sv ***
// Shared constants, types and float helpers for the strobe window width registers
package fww_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0]  IDX_STATUS       = 6'h00;
   localparam logic [5:0]  IDX_ABS_MIN      = 6'h05;
   localparam logic [5:0]  IDX_ABS_MAX      = 6'h09;
   localparam logic [5:0]  IDX_RAW_WIDTH    = 6'h0D;
   localparam logic [5:0]  IDX_RAW_MIN      = 6'h11;
   localparam logic [5:0]  IDX_RAW_MAX      = 6'h15;
   localparam logic [5:0]  IDX_FRAME_PERIOD = 6'h20;
   localparam logic [5:0]  IDX_ROI_HEIGHT   = 6'h21;

   // ----------------------------------------------------------------
   // Status codes and values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0]  STAT_UNAVAIL     = 8'h00;
   localparam logic [7:0]  STAT_OK          = 8'h01;
   localparam logic [7:0]  STAT_RANGE       = 8'h80;
   localparam logic [23:0] RAW_WIDTH_RST    = 24'h000003;
   localparam logic [23:0] FRAME_PERIOD_RST = 24'h000400;
   localparam logic [15:0] ROI_HEIGHT_RST   = 16'h0040;
   localparam logic [23:0] RAW_MIN_VAL      = 24'h000001;
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;

   // ----------------------------------------------------------------
   // Timing: quantum per model, in ns and in 50 MHz cycles
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS    = 20;
   localparam int          QUANT_NS_BASIC   = 4560;
   localparam int          QUANT_NS_MID     = 3455;
   localparam int          QUANT_NS_FAST    = 2764;
   localparam logic [11:0] QUANT_CYC_BASIC  = 12'((QUANT_NS_BASIC + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] QUANT_CYC_MID    = 12'((QUANT_NS_MID + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] QUANT_CYC_FAST   = 12'((QUANT_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Quantum in microseconds as single precision
   localparam logic [31:0] QUANT_FP_BASIC   = 32'h4091EB85;
   localparam logic [31:0] QUANT_FP_MID     = 32'h405D1EB8;
   localparam logic [31:0] QUANT_FP_FAST    = 32'h4030E560;

   typedef enum logic [1:0] {
      MODEL_BASIC = 2'b00,
      MODEL_MID   = 2'b01,
      MODEL_FAST  = 2'b10
   } fww_model_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACTIVE = 2'b01
   } fww_state_e;

   typedef struct packed {
      logic [23:0] raw_min;
      logic [23:0] raw_max;
      logic [31:0] abs_min;
      logic [31:0] abs_max;
   } fww_bounds_s;

   // Unsigned 24-bit integer to single precision, exact
   function automatic logic [31:0] fww_int_to_fp(input logic [23:0] v);
      logic [4:0]  p;
      logic [23:0] n;
      p = 5'h00;
      for (int i = 0; i < 24; i++) begin
         if (v[i]) begin
            p = 5'(i);
         end
      end
      n = v << (5'd23 - p);
      fww_int_to_fp = (v == 24'h000000) ? 32'h00000000 : {1'b0, 8'(8'd127 + {3'b000, p}), n[22:0]};
   endfunction : fww_int_to_fp

   // Product of two positive normal floats, truncated
   function automatic logic [31:0] fww_fp_mul(input logic [31:0] a, input logic [31:0] b);
      logic [47:0] prod;
      logic [9:0]  e;
      prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e    = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'd127 + {9'h000, prod[47]};
      if (a[30:0] == 31'h0) begin
         fww_fp_mul = 32'h00000000;
      end else if (prod[47]) begin
         fww_fp_mul = {1'b0, e[7:0], prod[46:24]};
      end else begin
         fww_fp_mul = {1'b0, e[7:0], prod[45:23]};
      end
   endfunction : fww_fp_mul

endpackage : fww_pkg

// *** core/fww_regs.sv ***
// Strobe window width register bank with AXI4-Lite slave and strobe generator
//
// Behaviour
// - Read-only index 0x05 holds the lowest allowed absolute width as a single precision float, kept current.
// - Read-only index 0x09 holds the highest allowed absolute width as a single precision float, kept current.
// - Software writes an integer multiplier to read/write index 0x0D to set the strobe window width.
// - The strobe window lasts the multiplier times a per-model quantum of 4.56, 3.455 or 2.764 us, each quantum rounded up to whole 50 MHz cycles.
// - The lower multiplier bound is fixed at 1; the upper is recomputed from frame period and readout region height.
// - The multiplier is 24 bits in the low three bytes; the top byte always reads zero.
// - Status at index 0x00 reads 0x00 unavailable, 0x01 available and valid, 0x80 out of range.
`timescale 1ns/10ps
module fww_regs import fww_pkg::*; #(
   parameter fww_model_e  MODEL     = MODEL_BASIC,
   parameter logic [11:0] ROW_TICKS = 12'h001,
   parameter logic        AVAILABLE = 1'b1
) (
   // Clock and reset
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // AXI4-Lite write address and data
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic [2:0]  s_axi_awprot,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   // AXI4-Lite read
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic [2:0]  s_axi_arprot,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   // Strobe
   input  wire  logic        strobe_trigger,
   output logic              strobe_window
);

   // ----------------------------------------------------------------
   // Model selection
   // ----------------------------------------------------------------
   localparam logic [11:0] QUANT_CYC = (MODEL == MODEL_FAST) ? QUANT_CYC_FAST :
                                       (MODEL == MODEL_MID)  ? QUANT_CYC_MID  : QUANT_CYC_BASIC;
   localparam logic [31:0] QUANT_FP  = (MODEL == MODEL_FAST) ? QUANT_FP_FAST :
                                       (MODEL == MODEL_MID)  ? QUANT_FP_MID  : QUANT_FP_BASIC;

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == IDX_STATUS) || (idx == IDX_ABS_MIN) || (idx == IDX_ABS_MAX) ||
               (idx == IDX_RAW_WIDTH) || (idx == IDX_RAW_MIN) || (idx == IDX_RAW_MAX) ||
               (idx == IDX_FRAME_PERIOD) || (idx == IDX_ROI_HEIGHT);
   endfunction : mapped

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // ----------------------------------------------------------------
   // Settings registers
   // ----------------------------------------------------------------
   logic [23:0] raw_width_q,    raw_width_d;
   logic [23:0] frame_period_q, frame_period_d;
   logic [15:0] roi_height_q,   roi_height_d;
   logic        wr_go;
   logic [5:0]  wr_idx;
   logic [31:0] wr_word;

   // Both channels taken together, only while no response is pending
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign wr_idx        = s_axi_awaddr[7:2];

   always_comb begin
      raw_width_d    = raw_width_q;
      frame_period_d = frame_period_q;
      roi_height_d   = roi_height_q;
      wr_word        = 32'h00000000;
      if (wr_go) begin
         case (wr_idx)
            IDX_RAW_WIDTH: begin
               wr_word     = merge({8'h00, raw_width_q}, s_axi_wdata, s_axi_wstrb);
               raw_width_d = wr_word[23:0];
            end
            IDX_FRAME_PERIOD: begin
               wr_word        = merge({8'h00, frame_period_q}, s_axi_wdata, s_axi_wstrb);
               frame_period_d = wr_word[23:0];
            end
            IDX_ROI_HEIGHT: begin
               wr_word      = merge({16'h0000, roi_height_q}, s_axi_wdata, s_axi_wstrb);
               roi_height_d = wr_word[15:0];
            end
            default: begin
               wr_word = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_width_q    <= RAW_WIDTH_RST;
         frame_period_q <= FRAME_PERIOD_RST;
         roi_height_q   <= ROI_HEIGHT_RST;
      end else begin
         raw_width_q    <= raw_width_d;
         frame_period_q <= frame_period_d;
         roi_height_q   <= roi_height_d;
      end
   end

   // ----------------------------------------------------------------
   // Bounds, refreshed one cycle after any setting changes
   // ----------------------------------------------------------------
   fww_bounds_s bnd_q, bnd_d;
   logic [35:0] readout_ticks;
   logic [35:0] spare_ticks;
   logic [7:0]  status;

   always_comb begin
      readout_ticks = 36'(roi_height_q) * 36'(ROW_TICKS);
      spare_ticks   = 36'(frame_period_q) - readout_ticks - 36'd1;
      bnd_d.raw_min = RAW_MIN_VAL;
      // Too little frame time left: range collapses to the minimum
      if (36'(frame_period_q) > readout_ticks + 36'd1 + 36'(RAW_MIN_VAL)) begin
         bnd_d.raw_max = spare_ticks[23:0];
      end else begin
         bnd_d.raw_max = RAW_MIN_VAL;
      end
      bnd_d.abs_min = fww_fp_mul(fww_int_to_fp(bnd_d.raw_min), QUANT_FP);
      bnd_d.abs_max = fww_fp_mul(fww_int_to_fp(bnd_d.raw_max), QUANT_FP);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bnd_q <= '0;
      end else begin
         bnd_q <= bnd_d;
      end
   end

   // Out of range judged against the registered bounds
   always_comb begin
      if (!AVAILABLE) begin
         status = STAT_UNAVAIL;
      end else if ((raw_width_q < bnd_q.raw_min) || (raw_width_q > bnd_q.raw_max)) begin
         status = STAT_RANGE;
      end else begin
         status = STAT_OK;
      end
   end

   // ----------------------------------------------------------------
   // Write response
   // ----------------------------------------------------------------
   logic       bvalid_q, bvalid_d;
   logic [1:0] bresp_q,  bresp_d;

   always_comb begin
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d  = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic        rvalid_q, rvalid_d;
   logic [1:0]  rresp_q,  rresp_d;
   logic [31:0] rdata_q,  rdata_d;
   logic        rd_go;
   logic [31:0] rd_word;

   assign rd_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_arready = !rvalid_q;

   always_comb begin
      case (s_axi_araddr[7:2])
         IDX_STATUS:       rd_word = {24'h000000, status};
         IDX_ABS_MIN:      rd_word = bnd_q.abs_min;
         IDX_ABS_MAX:      rd_word = bnd_q.abs_max;
         IDX_RAW_WIDTH:    rd_word = {8'h00, raw_width_q};
         IDX_RAW_MIN:      rd_word = {8'h00, bnd_q.raw_min};
         IDX_RAW_MAX:      rd_word = {8'h00, bnd_q.raw_max};
         IDX_FRAME_PERIOD: rd_word = {8'h00, frame_period_q};
         IDX_ROI_HEIGHT:   rd_word = {16'h0000, roi_height_q};
         default:          rd_word = 32'h00000000;
      endcase
      rvalid_d = rvalid_q;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (rd_go) begin
         rvalid_d = 1'b1;
         rdata_d  = rd_word;
         rresp_d  = mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else begin
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // ----------------------------------------------------------------
   // Strobe window generator
   // ----------------------------------------------------------------
   // Multiplier is latched at the trigger so a write mid-window cannot stretch it
   fww_state_e  state_q, state_d;
   logic [11:0] tick_q,  tick_d;
   logic [23:0] left_q,  left_d;
   logic        win_q,   win_d;

   always_comb begin
      state_d = state_q;
      tick_d  = tick_q;
      left_d  = left_q;
      win_d   = win_q;
      case (state_q)
         ST_IDLE: begin
            if (strobe_trigger && (raw_width_q != 24'h000000)) begin
               state_d = ST_ACTIVE;
               tick_d  = QUANT_CYC - 12'd1;
               left_d  = raw_width_q;
               win_d   = 1'b1;
            end
         end
         ST_ACTIVE: begin
            if (tick_q != 12'h000) begin
               tick_d = tick_q - 12'd1;
            end else if (left_q == 24'h000001) begin
               state_d = ST_IDLE;
               win_d   = 1'b0;
            end else begin
               tick_d = QUANT_CYC - 12'd1;
               left_d = left_q - 24'd1;
            end
         end
         default: begin
            state_d = ST_IDLE;
            win_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         tick_q  <= 12'h000;
         left_q  <= 24'h000000;
         win_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         tick_q  <= tick_d;
         left_q  <= left_d;
         win_q   <= win_d;
      end
   end

   assign strobe_window = win_q;

endmodule : fww_regs

// *** dv/fww_regs_assertions.sv ***
// Concurrent checks on the ports of the strobe window width register bank
`timescale 1ns/10ps
module fww_regs_sva import fww_pkg::*; #(
   parameter fww_model_e MODEL = MODEL_BASIC
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Strobe
   input wire logic        strobe_window
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   localparam logic [31:0] QFP = (MODEL == MODEL_MID) ? QUANT_FP_MID :
                                 (MODEL == MODEL_FAST) ? QUANT_FP_FAST : QUANT_FP_BASIC;
   localparam logic [31:0] QCYC = (MODEL == MODEL_MID) ? 32'(QUANT_CYC_MID) :
                                  (MODEL == MODEL_FAST) ? 32'(QUANT_CYC_FAST) : 32'(QUANT_CYC_BASIC);
   logic [31:0] hi_cnt_q;
   logic [31:0] hi_cnt_d;
   logic        rd_take;
   assign rd_take = s_axi_arvalid && !s_axi_rvalid;
   // Counts high cycles so the length check needs no long repetition
   always_comb begin
      hi_cnt_d = strobe_window ? hi_cnt_q + 32'h00000001 : 32'h00000000;
   end
   always_ff @(posedge aclk) begin
      hi_cnt_q <= aresetn ? hi_cnt_d : 32'h00000000;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write response missing one cycle after take");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read data missing one cycle after take");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");
   a_top_byte_zero: assert property (rd_take && s_axi_araddr[7:2] == IDX_RAW_WIDTH |=> s_axi_rdata[31:24] == 8'h00)
      else $error("multiplier top byte not zero");
   a_status_codes: assert property (rd_take && s_axi_araddr[7:2] == IDX_STATUS
      |=> s_axi_rdata inside {32'h00000000, 32'h00000001, 32'h00000080})
      else $error("status code outside the three defined values");
   a_abs_min_float: assert property ($past(aresetn, 2) && rd_take && s_axi_araddr[7:2] == IDX_ABS_MIN
      |=> s_axi_rdata == QFP)
      else $error("absolute lower bound is not one quantum");
   a_abs_max_order: assert property ($past(aresetn, 2) && rd_take && s_axi_araddr[7:2] == IDX_ABS_MAX
      |=> !s_axi_rdata[31] && s_axi_rdata >= QFP)
      else $error("absolute upper bound below lower bound");
   a_window_len: assert property ($fell(strobe_window) |-> hi_cnt_q != 0 && hi_cnt_q % QCYC == 0)
      else $error("strobe window not a whole number of quanta");
endmodule : fww_regs_sva

// *** dv/fww_regs_tb.sv ***
// Self-checking bench for the strobe window width register bank
`timescale 1ns/10ps
module fww_regs_tb import fww_pkg::*;;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, strobe_trigger, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, strobe_window;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          fail_count = 0;
   int          tests_run = 0;

   fww_regs dut (
      .aclk           (aclk),           .aresetn        (aresetn),
      .s_axi_awaddr   (s_axi_awaddr),   .s_axi_awprot   (s_axi_awprot),
      .s_axi_awvalid  (s_axi_awvalid),  .s_axi_awready  (s_axi_awready),
      .s_axi_wdata    (s_axi_wdata),    .s_axi_wstrb    (s_axi_wstrb),
      .s_axi_wvalid   (s_axi_wvalid),   .s_axi_wready   (s_axi_wready),
      .s_axi_bresp    (s_axi_bresp),    .s_axi_bvalid   (s_axi_bvalid),
      .s_axi_bready   (s_axi_bready),   .s_axi_araddr   (s_axi_araddr),
      .s_axi_arprot   (s_axi_arprot),   .s_axi_arvalid  (s_axi_arvalid),
      .s_axi_arready  (s_axi_arready),  .s_axi_rdata    (s_axi_rdata),
      .s_axi_rresp    (s_axi_rresp),    .s_axi_rvalid   (s_axi_rvalid),
      .s_axi_rready   (s_axi_rready),   .strobe_trigger (strobe_trigger),
      .strobe_window  (strobe_window)
   );

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_resp
   task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] resp);
      logic aw_left;
      logic w_left;
      @(posedge aclk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_left = 1'b1;
      w_left  = 1'b1;
      // Each channel is released at its own ready
      while (aw_left || w_left) begin
         @(posedge aclk);
         if (aw_left && s_axi_awready) begin
            aw_left = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_left && s_axi_wready) begin
            w_left = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      @(posedge aclk iff s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge aclk iff s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk iff s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_vals();
      logic [31:0] d;
      logic [1:0]  r;
      rd(IDX_RAW_WIDTH, d, r);
      chk("multiplier", {8'h00, RAW_WIDTH_RST}, d);
      rd(IDX_STATUS, d, r);
      chk("status", {24'h000000, STAT_OK}, d);
      rd(IDX_ABS_MIN, d, r);
      chk("abs min", QUANT_FP_BASIC, d);
      rd(IDX_RAW_MIN, d, r);
      chk("raw min", {8'h00, RAW_MIN_VAL}, d);
      $display("test reset_vals done");
   endtask : t_reset_vals
   task automatic t_bounds();
      logic [31:0] d;
      logic [1:0]  r;
      // Period 0x42 leaves no room past 0x40 lines, so the range collapses to one
      wr(IDX_ROI_HEIGHT, 32'h00000040, r);
      wr(IDX_FRAME_PERIOD, 32'h00000042, r);
      rd(IDX_RAW_MAX, d, r);
      chk("raw max floor", {8'h00, RAW_MIN_VAL}, d);
      rd(IDX_ABS_MAX, d, r);
      chk("abs max floor", QUANT_FP_BASIC, d);
      rd(IDX_STATUS, d, r);
      chk("status floor", {24'h000000, STAT_RANGE}, d);
      // Period 0x241 with height 0x40 leaves 512, a power of two, so the float is exact
      wr(IDX_FRAME_PERIOD, 32'h00000241, r);
      rd(IDX_RAW_MAX, d, r);
      chk("raw max", 32'h00000200, d);
      rd(IDX_ABS_MAX, d, r);
      chk("abs max", QUANT_FP_BASIC + 32'h04800000, d);
      $display("test bounds done");
   endtask : t_bounds
   task automatic t_mult();
      logic [31:0] d;
      logic [1:0]  r;
      wr(IDX_RAW_WIDTH, 32'hFF000005, r);
      chk_resp("write resp", RESP_OKAY, r);
      rd(IDX_RAW_WIDTH, d, r);
      chk_resp("read resp", RESP_OKAY, r);
      chk("multiplier", 32'h00000005, d);
      wr(IDX_RAW_WIDTH, 32'h00000201, r);
      rd(IDX_STATUS, d, r);
      chk("status above", {24'h000000, STAT_RANGE}, d);
      wr(IDX_RAW_WIDTH, 32'h00000000, r);
      rd(IDX_STATUS, d, r);
      chk("status below", {24'h000000, STAT_RANGE}, d);
      wr(IDX_RAW_WIDTH, 32'h00000200, r);
      rd(IDX_STATUS, d, r);
      chk("status edge", {24'h000000, STAT_OK}, d);
      wr(IDX_ABS_MIN, 32'h12345678, r);
      chk_resp("abs min wr resp", RESP_OKAY, r);
      rd(IDX_ABS_MIN, d, r);
      chk("abs min ro", QUANT_FP_BASIC, d);
      wr(6'h02, 32'h00000001, r);
      chk_resp("unmapped wr", RESP_SLVERR, r);
      rd(6'h02, d, r);
      chk_resp("unmapped rd", RESP_SLVERR, r);
      chk("unmapped data", 32'h00000000, d);
      $display("test mult done");
   endtask : t_mult
   task automatic t_strobe();
      int         n;
      logic [1:0] r;
      n = 0;
      // Multiplier zero: a trigger must give no window at all
      wr(IDX_RAW_WIDTH, 32'h00000000, r);
      strobe_trigger <= 1'b1;
      repeat (10) begin
         @(posedge aclk);
         strobe_trigger <= 1'b0;
         if (strobe_window === 1'b1) n++;
      end
      chk("zero window", 32'h00000000, 32'(n));
      n = 0;
      wr(IDX_RAW_WIDTH, 32'h00000002, r);
      @(posedge aclk);
      strobe_trigger <= 1'b1;
      @(posedge aclk);
      strobe_trigger <= 1'b0;
      // A retrigger mid window must not stretch it
      repeat (600) begin
         @(posedge aclk);
         if (strobe_window === 1'b1) n++;
         strobe_trigger <= (n == 100);
      end
      chk("window cycles", 32'(2 * QUANT_CYC_BASIC), 32'(n));
      $display("test strobe done");
   endtask : t_strobe
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      strobe_trigger = 1'b0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset_vals();
      t_bounds();
      t_mult();
      t_strobe();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      test_done();
   end
endmodule : fww_regs_tb

bind fww_regs fww_regs_sva #(.MODEL(MODEL)) u_sva (
   .aclk          (aclk),          .aresetn       (aresetn),
   .s_axi_awvalid (s_axi_awvalid), .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_bresp   (s_axi_bresp),   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),  .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid), .s_axi_rdata   (s_axi_rdata),
   .s_axi_rvalid  (s_axi_rvalid),  .s_axi_rready  (s_axi_rready),
   .strobe_window (strobe_window)
);
